// ===== agcl_pkg.sv
// Constants and types shared by the gain control loop files
package agcl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] AGCL_CTRL_MID_ADDR  = 6'h1c;
  localparam logic [7:0] AGCL_CTRL_MID_RESET = 8'h91;

  // Field positions inside gain_loop_control_mid
  localparam int AGCL_HYST_LSB = 6;  // gain_hysteresis_level, 7:6
  localparam int AGCL_WAIT_LSB = 4;  // settle wait select, 5:4
  localparam int AGCL_HOLD_LSB = 2;  // gain_hold_select, 3:2
  localparam int AGCL_LEN_LSB  = 0;  // averaging length / OOK boundary

  // ----------------------------------------------------------------
  // Counts and tables
  // ----------------------------------------------------------------
  // Settle wait is 8, 16, 24 or 32 samples: (select + 1) * 8
  localparam int         AGCL_WAIT_SHIFT = 3;
  // Averaging length is 8, 16, 32 or 64 samples: 8 << select
  localparam logic [6:0] AGCL_LEN_BASE   = 7'h08;
  localparam int         AGCL_LEN_SHIFT  = 3;
  // OOK boundary is 4, 8, 12 or 16 dB: (select + 1) * 4
  localparam int         AGCL_OOK_SHIFT  = 2;

  // Dead zone edges around the target, in magnitude steps
  localparam logic [3:0][3:0] AGCL_DZ_ABOVE = {4'h8, 4'h5, 4'h3, 4'h1};
  localparam logic [3:0][3:0] AGCL_DZ_BELOW = {4'h4, 4'h3, 4'h2, 4'h1};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AGCL_HOLD_NONE    = 2'h0,
    AGCL_HOLD_ON_SYNC = 2'h1,
    AGCL_HOLD_ANALOG  = 2'h2,
    AGCL_HOLD_ALL     = 2'h3
  } agcl_hold_t;

  typedef enum logic [1:0] {
    AGCL_ST_SETTLE = 2'b01,
    AGCL_ST_ACCUM  = 2'b10
  } agcl_state_t;

endpackage

// ===== agcl_avg_if.sv
// Link between the gain loop and its amplitude averager
interface agcl_avg_if #(
  parameter int MAG_W = 8
);
  logic             clear;
  logic             sample_valid;
  logic [MAG_W-1:0] mag;
  logic [1:0]       len_sel;
  logic             avg_valid;
  logic [MAG_W-1:0] avg;

  modport loop (
    output clear,
    output sample_valid,
    output mag,
    output len_sel,
    input  avg_valid,
    input  avg
  );

  modport avg_end (
    input  clear,
    input  sample_valid,
    input  mag,
    input  len_sel,
    output avg_valid,
    output avg
  );
endinterface

// ===== agcl_averager.sv
// Amplitude averager: sums a selectable number of samples
module agcl_averager #(
  parameter int MAG_W = 8
) (
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  agcl_avg_if.avg_end bus
);

  logic [6:0]       count;
  logic [MAG_W+5:0] sum;
  logic [6:0]       len_n;
  logic [MAG_W+5:0] next_sum;

  // Length is read live so a new select applies to this block of samples
  assign len_n    = agcl_pkg::AGCL_LEN_BASE << bus.len_sel;
  assign next_sum = sum + (MAG_W+6)'(bus.mag);

  // ----------------------------------------------------------------
  // Accumulate and emit one average per block
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count         <= 7'h00;
      sum           <= '0;
      bus.avg_valid <= 1'b0;
      bus.avg       <= '0;
    end else if (bus.clear) begin
      count         <= 7'h00;
      sum           <= '0;
      bus.avg_valid <= 1'b0;
    end else begin
      bus.avg_valid <= 1'b0;
      if (bus.sample_valid) begin
        // >= so a shortened length mid-block still ends the block
        if (count + 7'h01 >= len_n) begin
          bus.avg       <= MAG_W'(next_sum >>
                           (agcl_pkg::AGCL_LEN_SHIFT + int'(bus.len_sel)));
          bus.avg_valid <= 1'b1;
          sum           <= '0;
          count         <= 7'h00;
        end else begin
          sum   <= next_sum;
          count <= count + 7'h01;
        end
      end
    end
  end

endmodule

// ===== agcl_gain_control.sv
// Receiver automatic gain control loop with its control register
//
// Operation
// [RULE_01] Level 0..3 picks none, low, medium or large dead zone hysteresis.
// [RULE_02] After a gain step the loop waits 8, 16, 24 or 32 samples.
// [RULE_03] Hold select 0 adjusts gain whenever the dead zone is left.
// [RULE_04] Hold select 1 stops all gain changes once sync is found.
// [RULE_05] Hold select 2 fixes the analogue gain; digital still moves.
// [RULE_06] Hold select 3 fixes both gains for manual override.
// [RULE_07] The amplitude is averaged over 8, 16, 32 or 64 samples.
// [RULE_08] In OOK or ASK mode that field sets a 4, 8, 12 or 16 dB boundary.
// [RULE_09] A new setting applies at the next decision; gains are kept.
module agcl_gain_control #(
  parameter int MAG_W  = 8,
  parameter int GAIN_W = 3
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              reg_wr_en_i,
  input  wire logic              reg_rd_en_i,
  input  wire logic [5:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              sample_valid_i,
  input  wire logic [MAG_W-1:0]  sample_mag_i,
  input  wire logic [MAG_W-1:0]  mag_target_i,
  input  wire logic              sync_found_i,
  input  wire logic              rx_restart_i,
  input  wire logic              ook_mode_i,
  output logic      [GAIN_W-1:0] analog_gain_o,
  output logic      [GAIN_W-1:0] digital_gain_o,
  output logic      [MAG_W-1:0]  avg_mag_o,
  output logic                   ook_data_o,
  output logic                   settling_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [GAIN_W-1:0] GAIN_MAX = '1;

  logic [7:0]              gain_loop_control_mid;
  logic [1:0]              gain_hysteresis_level;
  logic [1:0]              wait_sel;
  agcl_pkg::agcl_hold_t    gain_hold_select;
  logic [1:0]              len_sel;
  agcl_pkg::agcl_state_t   state;
  logic [5:0]              settle_cnt;
  logic [5:0]              settle_n;
  logic                    sync_seen;
  logic                    analog_free;
  logic                    digital_free;
  logic signed [MAG_W+1:0] dev;
  logic                    too_high;
  logic                    too_low;
  logic                    step_down_a;
  logic                    step_down_d;
  logic                    step_up_d;
  logic                    step_up_a;
  logic                    stepped;
  logic [4:0]              ook_db;
  logic [MAG_W:0]          ook_lhs;

  agcl_avg_if #(.MAG_W(MAG_W)) avg_bus ();

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Fields are read live; wait and length selects act on each sample, the others at decisions
  assign gain_hysteresis_level =
    gain_loop_control_mid[agcl_pkg::AGCL_HYST_LSB +: 2];
  assign wait_sel  = gain_loop_control_mid[agcl_pkg::AGCL_WAIT_LSB +: 2];
  assign gain_hold_select = agcl_pkg::agcl_hold_t'(
    gain_loop_control_mid[agcl_pkg::AGCL_HOLD_LSB +: 2]);
  assign len_sel   = gain_loop_control_mid[agcl_pkg::AGCL_LEN_LSB +: 2];

  // Write store; a write touches only this byte, not the gain state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gain_loop_control_mid <= agcl_pkg::AGCL_CTRL_MID_RESET;
    end else if (reg_wr_en_i &&
                 reg_addr_i == agcl_pkg::AGCL_CTRL_MID_ADDR) begin
      gain_loop_control_mid <= reg_wdata_i;  // RULE_09
    end
  end

  // Read data, one cycle after the strobe; other addresses read zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_en_i) begin
      reg_rdata_o <= (reg_addr_i == agcl_pkg::AGCL_CTRL_MID_ADDR) ?
                     gain_loop_control_mid : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Hold policy
  // ----------------------------------------------------------------
  // Sync flag lives until the next receive restart; a sync in the same
  // cycle as the restart wins so the freeze is never missed
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_seen <= 1'b0;
    end else if (sync_found_i) begin
      sync_seen <= 1'b1;
    end else if (rx_restart_i) begin
      sync_seen <= 1'b0;
    end
  end

  // Which gain stages may move under the current hold select
  always_comb begin
    analog_free  = 1'b0;
    digital_free = 1'b0;
    unique case (gain_hold_select)
      agcl_pkg::AGCL_HOLD_NONE: begin
        analog_free  = 1'b1;  // RULE_03
        digital_free = 1'b1;  // RULE_03
      end
      agcl_pkg::AGCL_HOLD_ON_SYNC: begin
        analog_free  = !sync_seen;  // RULE_04
        digital_free = !sync_seen;  // RULE_04
      end
      agcl_pkg::AGCL_HOLD_ANALOG: begin
        digital_free = 1'b1;  // RULE_05
      end
      agcl_pkg::AGCL_HOLD_ALL: begin
        analog_free  = 1'b0;  // RULE_06
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Gain decision
  // ----------------------------------------------------------------
  // Deviation of the average from target, checked against the dead zone
  assign dev = $signed({2'b00, avg_bus.avg}) -
               $signed({2'b00, mag_target_i});
  assign too_high = dev > $signed({{(MAG_W-2){1'b0}},
    agcl_pkg::AGCL_DZ_ABOVE[gain_hysteresis_level]});  // RULE_01
  assign too_low = dev < -$signed({{(MAG_W-2){1'b0}},
    agcl_pkg::AGCL_DZ_BELOW[gain_hysteresis_level]});  // RULE_01

  // Reduce analogue gain first to protect the front end from overload;
  // raise digital first since it adds no noise figure penalty
  assign step_down_a = too_high && analog_free && analog_gain_o != '0;
  assign step_down_d = too_high && !step_down_a && digital_free &&
                       digital_gain_o != '0;
  assign step_up_d   = too_low && digital_free && digital_gain_o != GAIN_MAX;
  assign step_up_a   = too_low && !step_up_d && analog_free &&
                       analog_gain_o != GAIN_MAX;
  assign stepped     = avg_bus.avg_valid && state == agcl_pkg::AGCL_ST_ACCUM &&
                       (step_down_a || step_down_d || step_up_d || step_up_a);

  // Gains start at full and are never reset by a setting change
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_gain_o  <= GAIN_MAX;
      digital_gain_o <= GAIN_MAX;
    end else if (stepped) begin
      if (step_down_a) begin
        analog_gain_o <= analog_gain_o - GAIN_W'(1);
      end
      if (step_up_a) begin
        analog_gain_o <= analog_gain_o + GAIN_W'(1);
      end
      if (step_down_d) begin
        digital_gain_o <= digital_gain_o - GAIN_W'(1);
      end
      if (step_up_d) begin
        digital_gain_o <= digital_gain_o + GAIN_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Settle and accumulate sequence
  // ----------------------------------------------------------------
  // Settle length (select + 1) * 8; widened first so select 3 gives 32
  assign settle_n = 6'({1'b0, wait_sel} + 3'h1)
                    << agcl_pkg::AGCL_WAIT_SHIFT;  // RULE_02

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= agcl_pkg::AGCL_ST_SETTLE;
      settle_cnt <= 6'h00;
    end else if (rx_restart_i) begin
      state      <= agcl_pkg::AGCL_ST_SETTLE;
      settle_cnt <= 6'h00;
    end else begin
      unique case (state)
        agcl_pkg::AGCL_ST_SETTLE: begin
          if (sample_valid_i) begin
            if (settle_cnt + 6'h01 >= settle_n) begin  // RULE_02
              state      <= agcl_pkg::AGCL_ST_ACCUM;
              settle_cnt <= 6'h00;
            end else begin
              settle_cnt <= settle_cnt + 6'h01;
            end
          end
        end
        agcl_pkg::AGCL_ST_ACCUM: begin
          if (stepped) begin
            state <= agcl_pkg::AGCL_ST_SETTLE;  // RULE_02
          end
        end
        default: begin
          state      <= agcl_pkg::AGCL_ST_SETTLE;
          settle_cnt <= 6'h00;
        end
      endcase
    end
  end

  assign settling_o = state != agcl_pkg::AGCL_ST_ACCUM;

  // ----------------------------------------------------------------
  // Averager hookup
  // ----------------------------------------------------------------
  // Samples seen while settling are dropped, not accumulated
  assign avg_bus.clear        = settling_o || rx_restart_i;
  assign avg_bus.sample_valid = sample_valid_i;
  assign avg_bus.mag          = sample_mag_i;
  assign avg_bus.len_sel      = len_sel;  // RULE_07

  agcl_averager #(
    .MAG_W (MAG_W)
  ) u_averager (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .bus        (avg_bus.avg_end)
  );

  // Latest average, held for software and the OOK slicer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avg_mag_o <= '0;
    end else if (avg_bus.avg_valid) begin
      avg_mag_o <= avg_bus.avg;
    end
  end

  // ----------------------------------------------------------------
  // OOK slicer
  // ----------------------------------------------------------------
  // Mark when the sample is within the boundary below the average
  // Widened before the add so select 3 gives 16 dB, not a wrap to 0
  assign ook_db  = 5'({1'b0, len_sel} + 3'h1)
                   << agcl_pkg::AGCL_OOK_SHIFT;  // RULE_08
  assign ook_lhs = {1'b0, sample_mag_i} + (MAG_W+1)'(ook_db);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ook_data_o <= 1'b0;
    end else if (sample_valid_i && ook_mode_i) begin
      ook_data_o <= ook_lhs >= {1'b0, avg_mag_o};  // RULE_08
    end
  end

endmodule

// ===== agcl_gain_control_props.sv
// Port-level checker for the gain control loop
module agcl_gain_control_props #(
  parameter int MAG_W  = 8,
  parameter int GAIN_W = 3
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              reg_wr_en_i,
  input  wire logic              reg_rd_en_i,
  input  wire logic [5:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic [7:0]        reg_rdata_o,
  input  wire logic              sample_valid_i,
  input  wire logic [MAG_W-1:0]  sample_mag_i,
  input  wire logic              sync_found_i,
  input  wire logic              rx_restart_i,
  input  wire logic              ook_mode_i,
  input  wire logic [GAIN_W-1:0] analog_gain_o,
  input  wire logic [GAIN_W-1:0] digital_gain_o,
  input  wire logic [MAG_W-1:0]  avg_mag_o,
  input  wire logic              ook_data_o,
  input  wire logic              settling_o
);
  default clocking dck @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [7:0] cfg;
  logic [1:0] len_sel;
  logic       sync_seen;
  logic       hit;
  // Holds live in the register, so they are tracked from the write pins
  assign hit     = reg_addr_i == agcl_pkg::AGCL_CTRL_MID_ADDR;
  assign len_sel = cfg[1:0];

  // Register copy, same reset value as the design
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= agcl_pkg::AGCL_CTRL_MID_RESET;
    end else if (reg_wr_en_i && hit) begin
      cfg <= reg_wdata_i;
    end
  end

  // Sync flag; a set wins over a restart in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_seen <= 1'b0;
    end else if (sync_found_i) begin
      sync_seen <= 1'b1;
    end else if (rx_restart_i) begin
      sync_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_wr_mid;
    reg_wr_en_i && hit;
  endsequence
  sequence s_gap_then_rd;
    !reg_wr_en_i ##1 (reg_rd_en_i && hit);
  endsequence

  a_read_back_write: assert property (s_wr_mid ##1 s_gap_then_rd
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("read back bad");
  a_unmapped_zero: assert property (reg_rd_en_i && !hit
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd_en_i
    |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_one_step_only: assert property ($changed(analog_gain_o)
    |-> $stable(digital_gain_o) && (analog_gain_o - $past(analog_gain_o) == 1
    || $past(analog_gain_o) - analog_gain_o == 1)) else $error("bad step");
  a_step_then_settle: assert property ($changed(analog_gain_o)
    || $changed(digital_gain_o) |-> $rose(settling_o))
    else $error("no settle after step");
  a_settle_on_sample: assert property ($fell(settling_o)
    |-> $past(sample_valid_i)) else $error("settle ended without sample");
  a_hold_sync: assert property (cfg[3:2] == 2'h1 && sync_seen
    |=> $stable(analog_gain_o) && $stable(digital_gain_o))
    else $error("gain moved after sync");
  a_hold_analog: assert property (cfg[3:2] == 2'h2
    |=> $stable(analog_gain_o)) else $error("analogue gain moved");
  a_hold_both: assert property (cfg[3:2] == 2'h3
    |=> $stable(analog_gain_o) && $stable(digital_gain_o))
    else $error("gain moved while held");
  a_ook_slice: assert property (sample_valid_i && ook_mode_i
    |=> ook_data_o == ($past(sample_mag_i) + 4 * ($past(len_sel) + 1)
    >= $past(avg_mag_o))) else $error("slicer decision wrong");
endmodule

bind agcl_gain_control agcl_gain_control_props #(
  .MAG_W  (MAG_W),
  .GAIN_W (GAIN_W)
) u_props (
  .core_clk_i     (core_clk_i),
  .rst_n_i        (rst_n_i),
  .reg_wr_en_i    (reg_wr_en_i),
  .reg_rd_en_i    (reg_rd_en_i),
  .reg_addr_i     (reg_addr_i),
  .reg_wdata_i    (reg_wdata_i),
  .reg_rdata_o    (reg_rdata_o),
  .sample_valid_i (sample_valid_i),
  .sample_mag_i   (sample_mag_i),
  .sync_found_i   (sync_found_i),
  .rx_restart_i   (rx_restart_i),
  .ook_mode_i     (ook_mode_i),
  .analog_gain_o  (analog_gain_o),
  .digital_gain_o (digital_gain_o),
  .avg_mag_o      (avg_mag_o),
  .ook_data_o     (ook_data_o),
  .settling_o     (settling_o)
);

// ===== tb_agcl_gain_control.sv
// Self-checking bench for the gain control loop
module tb_agcl_gain_control;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Design and clock
  // ----------------------------------------------------------------
  logic       core_clk_i, rst_n_i, reg_wr_en_i, reg_rd_en_i;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, sample_mag_i, mag_target_i;
  logic [7:0] avg_mag_o, m;
  logic       sample_valid_i, sync_found_i, rx_restart_i, ook_mode_i;
  logic       ook_data_o, settling_o;
  logic [2:0] analog_gain_o, digital_gain_o, ea, ed;
  int         errors, checks;

  agcl_gain_control uut (
    .core_clk_i, .rst_n_i, .reg_wr_en_i, .reg_rd_en_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .sample_valid_i, .sample_mag_i,
    .mag_target_i, .sync_found_i, .rx_restart_i, .ook_mode_i,
    .analog_gain_o, .digital_gain_o, .avg_mag_o, .ook_data_o, .settling_o
  );

  // 200 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cg();
    chk({2'b00, analog_gain_o, digital_gain_o}, {2'b00, ea, ed}, "gain");
  endtask
  task automatic cs(input logic e);
    chk({7'h00, settling_o}, {7'h00, e}, "settling");
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_en_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_en_i <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_rd_en_i <= 1'b1;
    reg_addr_i  <= a;
    @(posedge core_clk_i);
    reg_rd_en_i <= 1'b0;
    #1 chk(reg_rdata_o, e, "read");
  endtask
  // Samples back to back, then time for the decision to land
  task automatic feed(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      sample_valid_i <= 1'b1;
      sample_mag_i   <= v;
    end
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  // Restart puts the loop in a known settle; sync comes just after
  task automatic rs(input logic s);
    @(posedge core_clk_i);
    rx_restart_i <= 1'b1;
    @(posedge core_clk_i);
    rx_restart_i <= 1'b0;
    sync_found_i <= s;
    @(posedge core_clk_i);
    sync_found_i <= 1'b0;
  endtask
  // One decision with wait 8 and length 8
  task automatic decide(input logic [7:0] v, input logic s);
    rs(s);
    feed(v, 16);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Guard against a hang
  initial begin
    #100us;
    errors++;
    $display("MISMATCH t=%0t run too long", $time);
    close_out();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    ea = 3'h7;
    ed = 3'h7;
    {rst_n_i, reg_wr_en_i, reg_rd_en_i, sample_valid_i} = 4'h0;
    {sync_found_i, rx_restart_i, ook_mode_i} = 3'h0;
    reg_addr_i = 6'h00;
    reg_wdata_i = 8'h00;
    sample_mag_i = 8'h00;
    mag_target_i = 8'h64;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1 cg();
    cs(1'b1);
    chk(avg_mag_o, 8'h00, "avg reset");
    rdc(6'h1c, 8'h91);
    wr(6'h1c, 8'h3a);
    rdc(6'h1c, 8'h3a);
    wr(6'h1d, 8'hff);
    rdc(6'h1d, 8'h00);
    rdc(6'h1c, 8'h3a);
    $display("test registers done");
    for (int w = 0; w < 4; w++) begin
      wr(6'h1c, {2'b00, 2'(w), 4'h0});
      rs(1'b0);
      feed(8'h64, (w + 1) * 8 - 1);
      cs(1'b1);
      feed(8'h64, 1);
      cs(1'b0);
    end
    $display("test settle wait done");
    for (int l = 0; l < 4; l++) begin
      wr(6'h1c, {6'h00, 2'(l)});
      rs(1'b0);
      feed(8'h78, 8 + (8 << l) - 1);
      cs(1'b0);
      feed(8'(8'h78 + (8 << l) - 1), 1);
      cs(1'b1);
      chk(avg_mag_o, 8'h78, "average");
      ea = ea - 3'h1;
      cg();
    end
    $display("test averaging length done");
    for (int h = 0; h < 4; h++) begin
      wr(6'h1c, {2'(h), 6'h00});
      m = 8'h64 + 8'(agcl_pkg::AGCL_DZ_ABOVE[h]);
      decide(m, 1'b0);
      cg();
      decide(m + 8'h01, 1'b0);
      ea = ea - 3'h1;
      cg();
      m = 8'h64 - 8'(agcl_pkg::AGCL_DZ_BELOW[h]);
      decide(m, 1'b0);
      cg();
      decide(m - 8'h01, 1'b0);
      ea = ea + 3'h1;
      cg();
    end
    $display("test hysteresis done");
    wr(6'h1c, 8'h0c);
    #1 cg();
    decide(8'h6e, 1'b0);
    cg();
    decide(8'h5a, 1'b0);
    cg();
    wr(6'h1c, 8'h08);
    decide(8'h6e, 1'b0);
    ed = ed - 3'h1;
    cg();
    decide(8'h5a, 1'b0);
    ed = ed + 3'h1;
    cg();
    wr(6'h1c, 8'h04);
    decide(8'h6e, 1'b0);
    ea = ea - 3'h1;
    cg();
    decide(8'h6e, 1'b1);
    cg();
    chk(avg_mag_o, 8'h6e, "average");
    $display("test gain holds done");
    ook_mode_i <= 1'b1;
    rs(1'b0);
    for (int l = 0; l < 4; l++) begin
      wr(6'h1c, {6'h03, 2'(l)});
      m = 8'h6e - 8'(4 * (l + 1));
      @(posedge core_clk_i);
      sample_valid_i <= 1'b1;
      sample_mag_i   <= m;
      @(posedge core_clk_i);
      sample_mag_i   <= m - 8'h01;
      #1 chk({7'h00, ook_data_o}, 8'h01, "slicer high");
      @(posedge core_clk_i);
      sample_valid_i <= 1'b0;
      #1 chk({7'h00, ook_data_o}, 8'h00, "slicer low");
    end
    $display("test slicer done");
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    ea = 3'h7;
    ed = 3'h7;
    #1 cg();
    cs(1'b1);
    chk(avg_mag_o, 8'h00, "avg reset");
    rdc(6'h1c, 8'h91);
    $display("test second reset done");
    close_out();
  end
endmodule
